// ==== logic/rxd_pkg.sv ====
package rxd_pkg;
  // register indices on the plain software port
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INT_STAT = 4'h1;
  localparam logic [3:0] REG_INT_MASK = 4'h2;
  localparam logic [3:0] REG_PKT_CNT = 4'h3;
  // control register fields
  localparam int CTRL_OFS_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // interrupt status / mask layout
  localparam int INT_W = 3;
  localparam int INT_PKT = 0;
  localparam int INT_ERR = 1;
  localparam int INT_NOBUF = 2;
  localparam logic [2:0] INT_NONE = 3'h0;
  // packet status bits in a returned descriptor
  localparam int ST_W = 6;
  localparam int ST_ERR_W = 5;
  localparam logic [5:0] ST_NONE = 6'h00;
  // count flag for a packet shorter than the fcs
  localparam logic [15:0] SHORT_FCS_FLAG = 16'h8000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [14:0] REF_NONE = 15'h0000;
  localparam logic [1:0] OFS_NONE = 2'h0;
  // ready queue element status
  localparam logic [1:0] RQ_OK = 2'h0;
  localparam logic [1:0] RQ_FAIL = 2'h1;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FETCH = 2'b01,
    S_DATA = 2'b10
  } rxd_state_t;

  // host-written part of a fetched descriptor
  typedef struct packed {
    logic [14:0] ref_id;
    logic [31:0] buf_addr;
    logic [15:0] buf_size;
  } rxd_fetch_t;

  // engine-written part of a descriptor
  typedef struct packed {
    logic [14:0] ref_id;
    logic [15:0] byte_cnt;
    logic chain_end;
    logic [1:0] offset;
    logic [5:0] status;
    logic [14:0] next_ref;
    logic [9:0] chan;
  } rxd_wb_t;

  typedef struct packed {
    logic [1:0] rq_status;
    logic [14:0] ref_id;
  } rxd_ready_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
  } rxd_wr_t;
endpackage

// ==== logic/rxd_writeback.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - buffer address and size come from host only
// - engine writes all other descriptor fields
// - chain end set only on final descriptor
// - fetched descriptors are single buffers, flag ignored
// - offset gives filler bytes before packet data
// - offset zero in all but first descriptor
// - status bits overrun..abort, bit five zero
// - status meaningful only in last descriptor
// - byte count excludes filler bytes
// - count above 32767 flags short-fcs packet
// - link descriptors through next reference field
// - every chain descriptor carries same channel code
// - buffer address valid in every descriptor
// - small first buffer, large rest, first queued
module rxd_writeback (
  input wire logic clk_i,
  input wire logic rstn_i,
  // software port
  input wire logic [rxd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // received packet bytes
  input wire logic in_valid_i,
  input wire logic [7:0] in_byte_i,
  input wire logic in_last_i,
  input wire logic [rxd_pkg::ST_ERR_W-1:0] in_status_i,
  input wire logic in_short_i,
  input wire logic [9:0] in_chan_i,
  output logic in_ready_o,
  // free queue fetch
  output logic fetch_req_o,
  output logic fetch_small_o,
  input wire logic fetch_ack_i,
  input wire logic fetch_empty_i,
  input wire rxd_pkg::rxd_fetch_t fetch_desc_i,
  // memory writes
  output logic wr_valid_o,
  output rxd_pkg::rxd_wr_t wr_o,
  output logic wb_valid_o,
  output rxd_pkg::rxd_wb_t wb_o,
  output logic rq_valid_o,
  output rxd_pkg::rxd_ready_t rq_o
);

  rxd_pkg::rxd_state_t state_reg, state_next;
  logic first_reg, first_next;
  logic [14:0] first_ref_reg, first_ref_next;
  logic [14:0] cur_ref_reg, cur_ref_next;
  logic [31:0] cur_addr_reg, cur_addr_next;
  logic [15:0] cur_size_reg, cur_size_next;
  logic [1:0] cur_ofs_reg, cur_ofs_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [9:0] chan_reg, chan_next;
  logic ready_reg, ready_next;
  logic freq_reg, freq_next;
  logic fsmall_reg, fsmall_next;
  logic wrv_reg, wrv_next;
  rxd_pkg::rxd_wr_t wr_reg, wr_next;
  logic wbv_reg, wbv_next;
  rxd_pkg::rxd_wb_t wb_reg, wb_next;
  logic rqv_reg, rqv_next;
  rxd_pkg::rxd_ready_t rq_reg, rq_next;
  logic [rxd_pkg::INT_W-1:0] ev_pkt;
  logic take;
  logic [15:0] fill;

  logic [31:0] ctrl_reg, ctrl_next;
  logic [rxd_pkg::INT_W-1:0] stat_reg, stat_next;
  logic [rxd_pkg::INT_W-1:0] mask_reg, mask_next;
  logic [15:0] pcnt_reg, pcnt_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  function automatic logic [31:0] rd_mux(input logic [3:0] a, input logic [31:0] c,
                                         input logic [2:0] s, input logic [2:0] m,
                                         input logic [15:0] p);
    rd_mux = 32'h0000_0000;
    unique case (a)
      rxd_pkg::REG_CTRL: rd_mux = c;
      rxd_pkg::REG_INT_STAT: rd_mux = {29'h0000_0000, s};
      rxd_pkg::REG_INT_MASK: rd_mux = {29'h0000_0000, m};
      rxd_pkg::REG_PKT_CNT: rd_mux = {16'h0000, p};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  assign take = in_valid_i && ready_reg;
  // filler plus stored bytes after this one
  assign fill = 16'(cnt_reg + rxd_pkg::CNT_ONE + {14'h0000, cur_ofs_reg});

  always_comb begin
    state_next = state_reg;
    first_next = first_reg;
    first_ref_next = first_ref_reg;
    cur_ref_next = cur_ref_reg;
    cur_addr_next = cur_addr_reg;
    cur_size_next = cur_size_reg;
    cur_ofs_next = cur_ofs_reg;
    cnt_next = cnt_reg;
    chan_next = chan_reg;
    fsmall_next = fsmall_reg;
    wrv_next = 1'b0;
    wr_next = wr_reg;
    wbv_next = 1'b0;
    wb_next = wb_reg;
    rqv_next = 1'b0;
    rq_next = rq_reg;
    ev_pkt = rxd_pkg::INT_NONE;
    unique case (state_reg)
      rxd_pkg::S_IDLE: begin
        if (ctrl_reg[rxd_pkg::CTRL_EN_BIT] && in_valid_i) begin
          state_next = rxd_pkg::S_FETCH;
          first_next = 1'b1;
          fsmall_next = 1'b1;
          chan_next = in_chan_i;
        end
      end
      rxd_pkg::S_FETCH: begin
        if (fetch_empty_i) begin
          ev_pkt[rxd_pkg::INT_NOBUF] = 1'b1;
        end
        if (fetch_ack_i) begin
          // only address, size and reference are taken from the fetch
          cur_ref_next = fetch_desc_i.ref_id;
          cur_addr_next = fetch_desc_i.buf_addr;
          cur_size_next = fetch_desc_i.buf_size;
          cnt_next = rxd_pkg::CNT_ZERO;
          state_next = rxd_pkg::S_DATA;
          first_next = 1'b0;
          if (first_reg) begin
            first_ref_next = fetch_desc_i.ref_id;
            cur_ofs_next = ctrl_reg[rxd_pkg::CTRL_OFS_LSB +: 2];
          end else begin
            cur_ofs_next = rxd_pkg::OFS_NONE;
            // close the previous buffer, linked to the new one
            wbv_next = 1'b1;
            wb_next.ref_id = cur_ref_reg;
            wb_next.byte_cnt = cnt_reg;
            wb_next.chain_end = 1'b0;
            wb_next.offset = cur_ofs_reg;
            wb_next.status = rxd_pkg::ST_NONE;
            wb_next.next_ref = fetch_desc_i.ref_id;
            wb_next.chan = chan_reg;
          end
        end
      end
      rxd_pkg::S_DATA: begin
        if (take) begin
          wrv_next = 1'b1;
          wr_next.addr = 32'(cur_addr_reg + {30'h0000_0000, cur_ofs_reg}
                         + {16'h0000, cnt_reg});
          wr_next.data = in_byte_i;
          cnt_next = 16'(cnt_reg + rxd_pkg::CNT_ONE);
          if (in_last_i) begin
            state_next = rxd_pkg::S_IDLE;
            wbv_next = 1'b1;
            wb_next.ref_id = cur_ref_reg;
            wb_next.byte_cnt = in_short_i ? (cnt_next | rxd_pkg::SHORT_FCS_FLAG)
                               : cnt_next;
            wb_next.chain_end = 1'b1;
            wb_next.offset = cur_ofs_reg;
            wb_next.status = {1'b0, in_status_i};
            wb_next.next_ref = rxd_pkg::REF_NONE;
            wb_next.chan = chan_reg;
            rqv_next = 1'b1;
            rq_next.ref_id = first_ref_reg;
            rq_next.rq_status = (|in_status_i || in_short_i) ? rxd_pkg::RQ_FAIL
                                : rxd_pkg::RQ_OK;
            ev_pkt[rxd_pkg::INT_PKT] = 1'b1;
            ev_pkt[rxd_pkg::INT_ERR] = |in_status_i || in_short_i;
          end else if (fill == cur_size_reg) begin
            state_next = rxd_pkg::S_FETCH;
            fsmall_next = 1'b0;
          end
        end
      end
      default: state_next = rxd_pkg::S_IDLE;
    endcase
    freq_next = (state_next == rxd_pkg::S_FETCH) && !fetch_ack_i;
    ready_next = (state_next == rxd_pkg::S_DATA);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= rxd_pkg::S_IDLE;
      first_reg <= 1'b0;
      first_ref_reg <= rxd_pkg::REF_NONE;
      cur_ref_reg <= rxd_pkg::REF_NONE;
      cur_addr_reg <= 32'h0000_0000;
      cur_size_reg <= rxd_pkg::CNT_ZERO;
      cur_ofs_reg <= rxd_pkg::OFS_NONE;
      cnt_reg <= rxd_pkg::CNT_ZERO;
      chan_reg <= 10'h000;
      ready_reg <= 1'b0;
      freq_reg <= 1'b0;
      fsmall_reg <= 1'b0;
      wrv_reg <= 1'b0;
      wr_reg <= '0;
      wbv_reg <= 1'b0;
      wb_reg <= '0;
      rqv_reg <= 1'b0;
      rq_reg <= '0;
    end else begin
      state_reg <= state_next;
      first_reg <= first_next;
      first_ref_reg <= first_ref_next;
      cur_ref_reg <= cur_ref_next;
      cur_addr_reg <= cur_addr_next;
      cur_size_reg <= cur_size_next;
      cur_ofs_reg <= cur_ofs_next;
      cnt_reg <= cnt_next;
      chan_reg <= chan_next;
      ready_reg <= ready_next;
      freq_reg <= freq_next;
      fsmall_reg <= fsmall_next;
      wrv_reg <= wrv_next;
      wr_reg <= wr_next;
      wbv_reg <= wbv_next;
      wb_reg <= wb_next;
      rqv_reg <= rqv_next;
      rq_reg <= rq_next;
    end
  end

  // register file; event set wins over read clear
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    pcnt_next = pcnt_reg;
    rdata_next = rxd_pkg::CTRL_RESET;
    if (reg_wr_i && reg_addr_i == rxd_pkg::REG_CTRL) begin
      ctrl_next = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == rxd_pkg::REG_INT_MASK) begin
      mask_next = reg_wdata_i[rxd_pkg::INT_W-1:0];
    end
    if (reg_rd_i) begin
      rdata_next = rd_mux(reg_addr_i, ctrl_reg, stat_reg, mask_reg, pcnt_reg);
      if (reg_addr_i == rxd_pkg::REG_INT_STAT) begin
        stat_next = rxd_pkg::INT_NONE;
      end
    end
    stat_next = stat_next | ev_pkt;
    if (ev_pkt[rxd_pkg::INT_PKT]) begin
      pcnt_next = 16'(pcnt_reg + rxd_pkg::CNT_ONE);
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= rxd_pkg::CTRL_RESET;
      mask_reg <= rxd_pkg::INT_NONE;
      stat_reg <= rxd_pkg::INT_NONE;
      pcnt_reg <= rxd_pkg::CNT_ZERO;
      rdata_reg <= rxd_pkg::CTRL_RESET;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      pcnt_reg <= pcnt_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign in_ready_o = ready_reg;
  assign fetch_req_o = freq_reg;
  assign fetch_small_o = fsmall_reg;
  assign wr_valid_o = wrv_reg;
  assign wr_o = wr_reg;
  assign wb_valid_o = wbv_reg;
  assign wb_o = wb_reg;
  assign rq_valid_o = rqv_reg;
  assign rq_o = rq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_chain_end_queue: assert property (
    wbv_reg && wb_reg.chain_end |-> rqv_reg && rq_reg.ref_id == first_ref_reg)
    else $error("final descriptor not paired with ready queue push");
  a_link_next_ref: assert property (
    wbv_reg && !wb_reg.chain_end |-> wb_reg.next_ref == cur_ref_reg
      && state_reg == rxd_pkg::S_DATA)
    else $error("link does not point at the new buffer");
  a_offset_later_zero: assert property (
    wbv_reg && wb_reg.ref_id != first_ref_reg |-> wb_reg.offset == rxd_pkg::OFS_NONE)
    else $error("non-first descriptor carries an offset");
  a_status_top_zero: assert property (
    wbv_reg |-> !wb_reg.status[rxd_pkg::ST_W-1])
    else $error("status bit five written as one");
  a_status_early_clear: assert property (
    wbv_reg && !wb_reg.chain_end |-> wb_reg.status == rxd_pkg::ST_NONE)
    else $error("status set in an earlier descriptor");
  a_no_overfill: assert property (
    state_reg == rxd_pkg::S_DATA |-> 17'(cnt_reg) + 17'(cur_ofs_reg) < 17'(cur_size_reg))
    else $error("buffer filled past its size");
  a_write_address: assert property (
    take |=> wrv_reg && wr_reg.addr == 32'($past(cur_addr_reg) + $past(cur_ofs_reg)
      + $past(cnt_reg)))
    else $error("byte stored at wrong buffer address");
  a_chan_stable: assert property (
    state_reg != rxd_pkg::S_IDLE && $past(state_reg) != rxd_pkg::S_IDLE |-> $stable(chan_reg))
    else $error("channel changed inside a chain");
  a_short_flag_only: assert property (
    wbv_reg && !wb_reg.chain_end |-> !wb_reg.byte_cnt[15])
    else $error("short flag set on a middle descriptor");
  a_first_small: assert property (
    freq_reg && first_reg |-> fsmall_reg)
    else $error("first buffer not taken from small queue");
  a_pkt_close: assert property (
    take && in_last_i |=> wbv_reg && wb_reg.chain_end && rqv_reg)
    else $error("last byte did not close the chain");
  a_short_from_input: assert property (
    wbv_reg && wb_reg.chain_end && wb_reg.byte_cnt[15] |-> $past(in_short_i))
    else $error("short flag set without a short packet");
  a_fetch_size_taken: assert property (
    state_reg == rxd_pkg::S_FETCH && fetch_ack_i |=> state_reg == rxd_pkg::S_DATA
      && cur_size_reg == $past(fetch_desc_i.buf_size))
    else $error("fetched buffer size not taken");

  c_single_buffer: cover property (
    state_reg == rxd_pkg::S_DATA && take && in_last_i && first_ref_reg == cur_ref_reg);
  c_chained: cover property (wbv_reg && !wb_reg.chain_end);
  c_no_buffer: cover property (state_reg == rxd_pkg::S_FETCH && fetch_empty_i);
  c_short_count: cover property (wbv_reg && wb_reg.byte_cnt[15]);
  c_irq_on_done: cover property (irq_reg && rqv_reg);

endmodule

// ==== tb/rxd_free_queue_model.sv ====
`timescale 1ns/1ns
module rxd_free_queue_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic small_i,
  input wire logic [3:0] delay_i,
  input wire logic no_buf_i,
  output logic ack_o,
  output logic empty_o,
  output rxd_pkg::rxd_fetch_t desc_o
);
  logic [14:0] ref_reg;
  logic [3:0] wait_reg;
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    empty_o <= 1'b0;
    // stale descriptor is inverted every cycle between answers, so it comes back every second cycle
    desc_o <= ~desc_o;
    if (!rstn_i) begin
      ref_reg <= 15'h0001;
      wait_reg <= 4'h0;
      desc_o <= '0;
    end else if (req_i && !ack_o && !empty_o) begin
      if (no_buf_i) begin
        empty_o <= 1'b1;
      end else if (wait_reg < delay_i) begin
        wait_reg <= wait_reg + 4'h1;
      end else begin
        ack_o <= 1'b1;
        wait_reg <= 4'h0;
        ref_reg <= ref_reg + 15'h0001;
        desc_o.ref_id <= ref_reg;
        desc_o.buf_addr <= {2'h1, ref_reg, 15'h0000};
        desc_o.buf_size <= small_i ? 16'h0010 : 16'h0020;
      end
    end
  end
endmodule

// ==== tb/rx_packet_descriptor_writeback_tb.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module rx_packet_descriptor_writeback_tb;
  typedef struct {int len; logic [1:0] ofs; logic [9:0] chan; logic [4:0] st; logic sh;} rxd_row_t;
  logic clk_i, rstn_i, reg_wr_i, reg_rd_i, irq_o, in_valid_i, in_last_i, in_short_i, in_ready_o;
  logic [3:0] reg_addr_i, delay;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [7:0] in_byte_i;
  logic [4:0] in_status_i;
  logic [9:0] in_chan_i;
  logic fetch_req_o, fetch_small_o, fetch_ack_i, fetch_empty_i, no_buf;
  logic wr_valid_o, wb_valid_o, rq_valid_o;
  rxd_pkg::rxd_fetch_t fetch_desc_i;
  rxd_pkg::rxd_wr_t wr_o;
  rxd_pkg::rxd_wb_t wb_o;
  rxd_pkg::rxd_ready_t rq_o;
  rxd_pkg::rxd_wr_t wrq[$], ewr[$];
  rxd_pkg::rxd_wb_t wbq[$], ewb[$];
  rxd_pkg::rxd_ready_t rqq[$];
  int errors = 0;
  int num_checks = 0;
  logic [14:0] ref_tb = 15'h0001;
  rxd_row_t rows[6] = '{'{5, 2'h0, 10'h3FF, 5'h00, 1'b0}, '{20, 2'h1, 10'h001, 5'h01, 1'b0},
    '{48, 2'h0, 10'h155, 5'h02, 1'b0}, '{60, 2'h3, 10'h2AA, 5'h04, 1'b0},
    '{3, 2'h2, 10'h00F, 5'h08, 1'b1}, '{16, 2'h0, 10'h0C3, 5'h10, 1'b0}};
  rxd_writeback uut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .in_valid_i(in_valid_i), .in_byte_i(in_byte_i),
    .in_last_i(in_last_i), .in_status_i(in_status_i), .in_short_i(in_short_i),
    .in_chan_i(in_chan_i), .in_ready_o(in_ready_o), .fetch_req_o(fetch_req_o),
    .fetch_small_o(fetch_small_o), .fetch_ack_i(fetch_ack_i), .fetch_empty_i(fetch_empty_i),
    .fetch_desc_i(fetch_desc_i), .wr_valid_o(wr_valid_o), .wr_o(wr_o),
    .wb_valid_o(wb_valid_o), .wb_o(wb_o), .rq_valid_o(rq_valid_o), .rq_o(rq_o));
  rxd_free_queue_model fq (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(fetch_req_o),
    .small_i(fetch_small_o), .delay_i(delay), .no_buf_i(no_buf), .ack_o(fetch_ack_i),
    .empty_o(fetch_empty_i), .desc_o(fetch_desc_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wr_valid_o === 1'b1) wrq.push_back(wr_o);
    if (wb_valid_o === 1'b1) wbq.push_back(wb_o);
    if (rq_valid_o === 1'b1) rqq.push_back(rq_o);
  end
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    v = reg_rdata_o;
  endtask
  task automatic run_pkt(input rxd_row_t r);
    rxd_pkg::rxd_wb_t ew;
    rxd_pkg::rxd_wr_t ea;
    rxd_pkg::rxd_ready_t er;
    int n, k, rem, cnt, g;
    wrq.delete();
    wbq.delete();
    rqq.delete();
    ewr.delete();
    ewb.delete();
    er = {(r.st != 5'h00 || r.sh) ? rxd_pkg::RQ_FAIL : rxd_pkg::RQ_OK, ref_tb};
    rem = r.len;
    k = 0;
    n = 0;
    while (rem > 0) begin
      cnt = (k == 0) ? 16 - r.ofs : 32;
      if (cnt > rem) cnt = rem;
      for (int i = 0; i < cnt; i++) begin
        ea.addr = 32'h4000_0000 + (32'(ref_tb) << 15) + ((k == 0) ? r.ofs : 0) + i;
        ea.data = 8'(n);
        n++;
        ewr.push_back(ea);
      end
      rem -= cnt;
      ew = '0;
      ew.ref_id = ref_tb;
      ew.byte_cnt = 16'(cnt);
      ew.chain_end = (rem == 0);
      ew.offset = (k == 0) ? r.ofs : 2'h0;
      ew.chan = r.chan;
      if (rem == 0) begin
        ew.status = {1'b0, r.st};
        if (r.sh) ew.byte_cnt |= 16'h8000;
      end else begin
        ew.next_ref = ref_tb + 15'h0001;
      end
      ewb.push_back(ew);
      ref_tb++;
      k++;
    end
    @(posedge clk_i);
    in_valid_i <= 1'b1;
    in_byte_i <= 8'h00;
    in_last_i <= (r.len == 1);
    in_status_i <= r.st;
    in_short_i <= r.sh;
    in_chan_i <= r.chan;
    n = 0;
    g = 0;
    while (n < r.len && g < 3000) begin
      @(posedge clk_i);
      g++;
      if (in_ready_o === 1'b1) begin
        n++;
        in_byte_i <= 8'(n);
        in_last_i <= (n == r.len - 1);
        if (n == r.len) in_valid_i <= 1'b0;
      end
    end
    while (rqq.size() == 0 && g < 3000) begin
      @(posedge clk_i);
      g++;
    end
    repeat (2) @(posedge clk_i);
    `CHK(wbq.size(), ewb.size())
    for (int i = 0; i < ewb.size() && i < wbq.size(); i++) begin
      if (ewb[i].chain_end) ewb[i].next_ref = wbq[i].next_ref;
      `CHK(wbq[i], ewb[i])
    end
    `CHK(wrq.size(), ewr.size())
    for (int i = 0; i < ewr.size() && i < wrq.size(); i++) `CHK(wrq[i], ewr[i])
    `CHK(rqq[0], er)
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, in_valid_i, in_last_i, in_short_i, no_buf} = '0;
    {reg_addr_i, reg_wdata_i, in_byte_i, in_status_i, in_chan_i, delay} = '0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    reg_rd(rxd_pkg::REG_CTRL, d);
    `CHK(d, rxd_pkg::CTRL_RESET)
    in_valid_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(fetch_req_o, 1'b0)
    in_valid_i <= 1'b0;
    reg_wr(rxd_pkg::REG_INT_MASK, 32'h0000_0007);
    reg_wr(rxd_pkg::REG_INT_STAT, 32'hFFFF_FFFF);
    reg_rd(rxd_pkg::REG_INT_STAT, d);
    `CHK(d, 32'h0000_0000)
    reg_rd(4'hF, d);
    `CHK(d, 32'h0000_0000)
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      reg_wr(rxd_pkg::REG_CTRL, {29'h0, 1'b1, rows[i].ofs});
      run_pkt(rows[i]);
      `CHK(irq_o, 1'b1)
      reg_rd(rxd_pkg::REG_INT_STAT, d);
      `CHK(d, {30'h0, (rows[i].st != 5'h00 || rows[i].sh), 1'b1})
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      $display("test row %0d done", i);
    end
    reg_rd(rxd_pkg::REG_PKT_CNT, d);
    `CHK(d, 32'h0000_0006)
    no_buf <= 1'b1;
    delay <= 4'h3;
    fork
      begin
        repeat (30) @(posedge clk_i);
        no_buf <= 1'b0;
        repeat (3) @(posedge clk_i);
        reg_rd(rxd_pkg::REG_INT_STAT, d);
        `CHK(d, 32'h0000_0004)
      end
      run_pkt(rxd_row_t'{60, 2'h0, 10'h0AA, 5'h00, 1'b0});
    join
    reg_rd(rxd_pkg::REG_INT_STAT, d);
    `CHK(d, 32'h0000_0001)
    $display("test no buffer done");
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    reg_rd(rxd_pkg::REG_CTRL, d);
    `CHK(d, rxd_pkg::CTRL_RESET)
    reg_rd(rxd_pkg::REG_PKT_CNT, d);
    `CHK(d, 32'h0000_0000)
    $display("test reset done");
    print_verdict();
  end
endmodule
